// file: logic/cepwm_sequencer.sv
// Purpose: Charge enable qualification, soft-start and gate sequencing.
// Assumes: Flags are asynchronous comparator outputs; settings arrive already decoded as words.
// Notes:   The open-drain adapter-good pin is modelled as an output enable pulling low.
`timescale 1ns/1ps
`include "cepwm_defines.svh"
module cepwm_sequencer
  import cepwm_pkg::*;
#(
  parameter int unsigned ADAPTER_GOOD_OUT_CYC  = (`CEPWM_ADAPTER_GOOD_OUT_DELAY_US * `CEPWM_CLK_MHZ),
  parameter int unsigned DET_CYC   = (`CEPWM_DETECT_DELAY_US * `CEPWM_CLK_MHZ),
  parameter int unsigned CE_CYC    = (`CEPWM_CE_DELAY_US * `CEPWM_CLK_MHZ),
  parameter int unsigned STEP_CYC  = (`CEPWM_STEP_US * `CEPWM_CLK_MHZ),
  parameter int unsigned PER_CYC   = (`CEPWM_CLK_MHZ * 1000 / `CEPWM_SW_KHZ)
) (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire cepwm_flags_type flagsAsync,
  input  wire logic [15:0]     chargeVoltageSetting,
  input  wire logic [15:0]     chargeCurrentSetting,
  input  wire logic [15:0]     inputCurrentLimit,
  input  wire logic            inputCurrentLimitWrite,
  output logic                 adapterGoodOutOe,
  output logic                 inputCurrentMonitorEnable,
  output logic                 biasEnable,
  output logic                 chargeEnabled,
  output logic [5:0]           chargeRegulationLimit,
  output logic [5:0]           inputLimitField,
  output cepwm_gates_type      gates
);
  localparam int unsigned DEAD_CYC  = (`CEPWM_DEAD_NS + `CEPWM_CLK_NS - 1) / `CEPWM_CLK_NS;
  localparam int unsigned PULSE_CYC = (`CEPWM_PULSE_NS + `CEPWM_CLK_NS - 1) / `CEPWM_CLK_NS;
  localparam int unsigned BLANK_CYC = (`CEPWM_BLANK_NS + `CEPWM_CLK_NS - 1) / `CEPWM_CLK_NS;

  // ==========================================================================
  // Input synchronisers
  cepwm_flags_type syncA;
  cepwm_flags_type flg;
  always_ff @(posedge clk) begin
    syncA <= flagsAsync;
    flg   <= syncA;
  end

  function automatic logic [5:0] fieldOf(input logic [15:0] w);
    return w[`CEPWM_FIELD_LSB +: `CEPWM_FIELD_W];
  endfunction

  // ==========================================================================
  // Input current limit register, resets to its lowest step
  logic [5:0] next_inputLimitField;
  always_comb begin
    next_inputLimitField = inputLimitField;
    if (!rst_n) begin
      next_inputLimitField = 6'h01;
    end else if (inputCurrentLimitWrite) begin
      next_inputLimitField = fieldOf(inputCurrentLimit);
    end
  end
  always_ff @(posedge clk) begin
    inputLimitField <= next_inputLimitField;
  end

  // ==========================================================================
  // Adapter qualification and enable
  logic [31:0] acokCnt, detCnt, ceCnt;
  logic [31:0] next_acokCnt, next_detCnt, next_ceCnt;
  logic        next_adapterGoodOutOe, next_monitor, next_bias, next_chargeEnabled;
  logic        settingsValid, okToCharge, mustStop;

  always_comb begin
    settingsValid = (fieldOf(chargeCurrentSetting) != 6'h00) && (chargeVoltageSetting != 16'h0000)
                    && (inputLimitField > 6'h01);
    okToCharge = flg.supplyAbove4v5 && flg.logicAbove2v5 && flg.detectAbove2v4
                 && flg.adapterAboveBattery && flg.gateDriveValid && flg.referenceValid
                 && !flg.thermalShutdown && flg.chargeEnablePin
                 && (detCnt >= DET_CYC) && (ceCnt >= CE_CYC)
                 && (acokCnt >= ADAPTER_GOOD_OUT_CYC) && settingsValid;
    mustStop = !flg.chargeEnablePin || !flg.supplyAbove4v || !flg.logicAbove2v35
               || !flg.adapterAboveBattery || flg.batteryOvervoltage || flg.thermalShutdown
               || !settingsValid || !flg.detectAbove2v4;
    next_acokCnt = 32'h0;
    next_detCnt  = 32'h0;
    next_ceCnt   = 32'h0;
    if (flg.supplyAbove4v5 && flg.detectAbove2v4) begin
      next_acokCnt = (acokCnt < ADAPTER_GOOD_OUT_CYC) ? acokCnt + 32'h1 : acokCnt;
      next_detCnt  = (detCnt < DET_CYC) ? detCnt + 32'h1 : detCnt;
      if (flg.chargeEnablePin) begin
        next_ceCnt = (ceCnt < CE_CYC) ? ceCnt + 32'h1 : ceCnt;
      end
    end
    next_bias    = flg.supplyAbove4v5 && flg.detectAbove0v6;
    next_monitor = next_bias;
    // Pulling low is the default; release only after the qualification delay.
    next_adapterGoodOutOe = !(next_bias && next_acokCnt >= ADAPTER_GOOD_OUT_CYC);
    if (!flg.supplyAbove4v) begin
      next_chargeEnabled = 1'b0;
    end else if (chargeEnabled) begin
      next_chargeEnabled = !mustStop;
    end else begin
      next_chargeEnabled = okToCharge && !mustStop;
    end
    if (!rst_n) begin
      next_acokCnt = 32'h0;
      next_detCnt  = 32'h0;
      next_ceCnt   = 32'h0;
      next_bias    = 1'b0;
      next_monitor = 1'b0;
      next_adapterGoodOutOe = 1'b1;
      next_chargeEnabled = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    acokCnt <= next_acokCnt;
    detCnt  <= next_detCnt;
    ceCnt   <= next_ceCnt;
    biasEnable <= next_bias;
    inputCurrentMonitorEnable <= next_monitor;
    adapterGoodOutOe <= next_adapterGoodOutOe;
    chargeEnabled <= next_chargeEnabled;
  end

  // ==========================================================================
  // Soft-start ramp
  logic [3:0]  ssStep, next_ssStep;
  logic [31:0] ssCnt, next_ssCnt;
  logic [5:0]  next_limit;
  logic [9:0]  scaled;
  always_comb begin
    next_ssStep = ssStep;
    next_ssCnt  = ssCnt;
    if (!chargeEnabled) begin
      next_ssStep = 4'h0;
      next_ssCnt  = 32'h0;
    end else if (ssStep < 4'(`CEPWM_SS_STEPS)) begin
      if (ssCnt >= STEP_CYC - 1) begin
        next_ssCnt  = 32'h0;
        next_ssStep = ssStep + 4'h1;
      end else begin
        next_ssCnt = ssCnt + 32'h1;
      end
    end
    // Live setting scaled each cycle, so mid-charge changes apply at once.
    // Both factors are widened first; a six-bit product would wrap at full scale.
    scaled = (10'(fieldOf(chargeCurrentSetting)) * 10'(ssStep)) / 10'(`CEPWM_SS_STEPS);
    next_limit = chargeEnabled ? scaled[5:0] : 6'h00;
    if (!rst_n) begin
      next_ssStep = 4'h0;
      next_ssCnt  = 32'h0;
      next_limit  = 6'h00;
    end
  end
  always_ff @(posedge clk) begin
    ssStep <= next_ssStep;
    ssCnt  <= next_ssCnt;
    chargeRegulationLimit <= next_limit;
  end

  // ==========================================================================
  // Gate sequencer
  cepwm_phase_type phase, next_phase;
  logic [15:0]     perCnt, next_perCnt;
  logic [7:0]      phCnt, next_phCnt;
  logic [1:0]      bootCycles, next_bootCycles;
  logic            refresh, next_refresh, ucpLatch, next_ucpLatch;
  cepwm_gates_type next_gates;
  logic            cycleStart;
  logic            startDue;
  always_comb begin
    cycleStart = (perCnt == 16'(PER_CYC - 1));
    startDue = (perCnt == 16'(DEAD_CYC - 1));
    next_perCnt = cycleStart ? 16'h0 : perCnt + 16'h1;
    next_phase = phase;
    next_phCnt = phCnt + 8'h1;
    next_bootCycles = bootCycles;
    next_refresh = refresh;
    next_ucpLatch = ucpLatch;
    if (cycleStart) begin
      next_ucpLatch = 1'b0;
      if (flg.bootLow && bootCycles < 2'(`CEPWM_BOOT_CYCLES)) begin
        next_bootCycles = bootCycles + 2'h1;
      end else if (!flg.bootLow) begin
        next_bootCycles = 2'h0;
      end
      if (flg.bootLow && bootCycles == 2'(`CEPWM_BOOT_CYCLES)) begin
        next_refresh = 1'b1;
      end
    end
    case (phase)
      PH_IDLE: begin
        // The high side waits one dead time into the cycle, so low-to-high keeps the same gap.
        if (chargeEnabled && startDue) begin
          next_phCnt = 8'h0;
          if (refresh || (flg.errorBelowFloor && flg.bootLow)) begin
            next_phase = PH_DEAD;
            next_refresh = 1'b1;
          end else if (!flg.errorBelowFloor) begin
            next_phase = PH_HIGH;
          end
        end
      end
      PH_HIGH: begin
        if (!chargeEnabled || cycleStart) begin
          next_phase = PH_IDLE;
        end else if (!flg.errorAboveRamp) begin
          next_phase = PH_DEAD;
          next_phCnt = 8'h0;
        end
      end
      PH_DEAD: begin
        if (!chargeEnabled) begin
          next_phase = PH_IDLE;
        end else if (phCnt >= 8'(DEAD_CYC - 1)) begin
          next_phase = PH_LOW;
          next_phCnt = 8'h0;
        end
      end
      PH_LOW: begin
        if (!chargeEnabled || cycleStart) begin
          next_phase = PH_IDLE;
        end else if (refresh && phCnt >= 8'(PULSE_CYC - 1)) begin
          next_phase = PH_OFF;
          next_refresh = 1'b0;
          next_bootCycles = 2'h0;
        end else if (!refresh && phCnt >= 8'(BLANK_CYC) && flg.senseBelowUcp) begin
          next_phase = PH_OFF;
          next_ucpLatch = 1'b1;
        end
      end
      PH_OFF: begin
        if (cycleStart || !chargeEnabled) begin
          next_phase = PH_IDLE;
        end
      end
      default: next_phase = PH_IDLE;
    endcase
    // High always passes through dead before low, and each cycle opens with a dead time of idle unless a dead phase runs across the cycle start.
    next_gates.highGate = (next_phase == PH_HIGH);
    next_gates.lowGate  = (next_phase == PH_LOW) && !next_ucpLatch;
    if (!rst_n) begin
      next_perCnt = 16'h0;
      next_phase = PH_IDLE;
      next_phCnt = 8'h0;
      next_bootCycles = 2'h0;
      next_refresh = 1'b0;
      next_ucpLatch = 1'b0;
      next_gates = '0;
    end
  end
  always_ff @(posedge clk) begin
    perCnt <= next_perCnt;
    phase <= next_phase;
    phCnt <= next_phCnt;
    bootCycles <= next_bootCycles;
    refresh <= next_refresh;
    ucpLatch <= next_ucpLatch;
    gates <= next_gates;
  end

  // ==========================================================================
  // Checks
  a_no_shoot_through: assert property (@(posedge clk) disable iff (!rst_n)
    !(gates.highGate && gates.lowGate)) else $error("both gates on");
  a_supply_low_off: assert property (@(posedge clk) disable iff (!rst_n)
    !flg.supplyAbove4v |=> !chargeEnabled) else $error("charging with low supply");
  a_stop_on_pin: assert property (@(posedge clk) disable iff (!rst_n)
    !flg.chargeEnablePin |=> !chargeEnabled) else $error("charging with enable low");
  a_adapter_good_out_low_bias: assert property (@(posedge clk) disable iff (!rst_n)
    !biasEnable |-> adapterGoodOutOe) else $error("adapter good released without bias");
  a_gate_off_disabled: assert property (@(posedge clk) disable iff (!rst_n)
    !chargeEnabled |=> !gates.highGate) else $error("high gate while disabled");
  a_ramp_restart: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(chargeEnabled) |-> ssStep == 4'h0) else $error("ramp not from zero");
  a_ss_step_bounds: assert property (@(posedge clk) disable iff (!rst_n)
    ssStep <= 4'(`CEPWM_SS_STEPS)) else $error("ramp overran");
  a_ucp_latch_off: assert property (@(posedge clk) disable iff (!rst_n)
    ucpLatch |-> !gates.lowGate) else $error("low gate on after cutoff");
  a_enable_needs_pin: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(chargeEnabled) |-> $past(flg.chargeEnablePin) && ceCnt >= CE_CYC) else $error("early enable");
endmodule

// file: logic/cepwm_defines.svh
// Purpose: Constants for the charge enable and PWM sequencer.
// Assumes: 125 MHz core clock, 8 ns period.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
// Summary of operation
// - Adapter supply below 4 V keeps the charger disabled.
// - Detect below 0.6 V with supply good holds adapter-good and monitor low.
// - Detect above 0.6 V enables bias; adapter-good stays low below 2.4 V.
// - 100 us after detect passes 2.4 V, release adapter-good and allow charging.
// - Charging needs supply above 4.5 V, logic supply above 2.5 V, detect above 2.4 V.
// - Charging waits 200 us after adapter detection.
// - Charging waits 2 ms after detection and enable pin both high.
// - All three settings must be in range; out of range stops charging.
// - Needs adapter above battery, supplies valid, no thermal flag, enable high.
// - Enable low, supply low, logic supply low, overvoltage or heat stop charging.
// - Each enable ramps charge current from zero in eight equal steps.
// - Each step lasts about 1.6 ms, whole ramp about 12.8 ms.
// - Setting changes during charging take effect at once, no new ramp.
// - Switching cycle runs at a fixed 300 kHz from the internal clock.
// - Bootstrap low over three cycles forces high side off, low side on.
// - After recharge return to full duty; reissue whenever bootstrap low again.
// - High side turns on each cycle start; ramp compare ends on-time. The code turns it on one dead time after the cycle start.
// - About 25 ns break-before-make with both switches off.
// - In continuous mode low side stays on until cycle end.
// - After blank-out, sense below 10 mV latches low side off till next cycle.
// - At zero duty neither switch turns on, except one recharge pulse.
// - Each low-side recharge pulse lasts about 40 ns.
`ifndef CEPWM_DEFINES_SVH
`define CEPWM_DEFINES_SVH
`define CEPWM_CLK_MHZ          125
`define CEPWM_ADAPTER_GOOD_OUT_DELAY_US    100
`define CEPWM_DETECT_DELAY_US  200
`define CEPWM_CE_DELAY_US      2000
`define CEPWM_STEP_US          1600
`define CEPWM_SW_KHZ           300
`define CEPWM_DEAD_NS          25
`define CEPWM_PULSE_NS         40
`define CEPWM_BLANK_NS         100
`define CEPWM_CLK_NS           8
`define CEPWM_SS_STEPS         8
`define CEPWM_BOOT_CYCLES      3
`define CEPWM_ICL_OFFSET       8'h3F
`define CEPWM_FIELD_LSB        7
`define CEPWM_FIELD_W          6
`endif

// file: logic/cepwm_pkg.sv
// Purpose: Types for the charge enable and PWM sequencer.
// Assumes: Constants come from cepwm_defines.svh.
// Notes:   Flags travel together as one packed struct.
package cepwm_pkg;
  typedef struct packed {
    logic supplyAbove4v;
    logic supplyAbove4v5;
    logic logicAbove2v5;
    logic logicAbove2v35;
    logic detectAbove0v6;
    logic detectAbove2v4;
    logic adapterAboveBattery;
    logic gateDriveValid;
    logic referenceValid;
    logic thermalShutdown;
    logic batteryOvervoltage;
    logic bootLow;
    logic senseBelowUcp;
    logic errorAboveRamp;
    logic errorBelowFloor;
    logic chargeEnablePin;
  } cepwm_flags_type;
  typedef enum logic [2:0] {PH_IDLE, PH_HIGH, PH_DEAD, PH_LOW, PH_OFF} cepwm_phase_type;
  typedef struct packed {
    logic highGate;
    logic lowGate;
  } cepwm_gates_type;
endpackage

// file: tb/cepwm_power_stage.sv
// Purpose: Behavioural power stage and ramp comparator facing the gate outputs.
// Assumes: Gates are active high; the comparator levels are plain analog results.
// Notes:   Ramp and undercurrent timing are counted from each gate turning on.
`timescale 1ns/1ps
module cepwm_power_stage
  import cepwm_pkg::*;
(
  input  wire logic            clk,
  input  wire cepwm_gates_type gates,
  input  wire logic [7:0]      dutyCyc,
  input  wire logic [7:0]      ucpCyc,
  output logic                 errorAboveRamp,
  output logic                 senseBelowUcp,
  output logic                 overlapSeen
);
  // ==========================================================================
  // Conduction counters
  logic [7:0] highCount;
  logic [7:0] lowCount;

  initial begin
    highCount   = 8'h00;
    lowCount    = 8'h00;
    overlapSeen = 1'b0;
  end

  always @(posedge clk) begin
    highCount <= gates.highGate ? highCount + 8'h01 : 8'h00;
    lowCount  <= gates.lowGate ? lowCount + 8'h01 : 8'h00;
    // Both switches on would short the adapter rail to ground.
    if (gates.highGate && gates.lowGate) begin
      overlapSeen <= 1'b1;
    end
  end

  // The error signal sits above the ramp until the duty count has run out.
  assign errorAboveRamp = gates.highGate ? (highCount < dutyCyc) : 1'b1;
  // Inductor current falls under the cutoff once the low side has conducted long enough.
  assign senseBelowUcp  = gates.lowGate && (lowCount > ucpCyc);
endmodule

// file: tb/testbench.sv
// Purpose: Self-checking bench for the charge enable and PWM sequencer.
// Assumes: Shortened delay parameters; comparator flags are driven as levels.
// Notes:   Outputs are sampled 1 ns after an edge so that edge updates have landed.
`timescale 1ns/1ps
module testbench;
  import cepwm_pkg::*;
  localparam int unsigned CE_CYC = 40;
  localparam int unsigned STEP_CYC = 16;
  // ==========================================================================
  // Signals
  logic            clk;
  logic            rst_n;
  cepwm_flags_type flags;
  cepwm_flags_type flagsAsync;
  logic [15:0]     chargeVoltageSetting;
  logic [15:0]     chargeCurrentSetting;
  logic [15:0]     inputCurrentLimit;
  logic            inputCurrentLimitWrite;
  logic            adapterGoodOutOe;
  logic            inputCurrentMonitorEnable;
  logic            biasEnable;
  logic            chargeEnabled;
  logic [5:0]      chargeRegulationLimit;
  logic [5:0]      inputLimitField;
  cepwm_gates_type gates;
  logic            errorAboveRamp;
  logic            senseBelowUcp;
  logic            overlapSeen;
  logic            prevHigh;
  logic            gateSeen;
  logic [7:0]      dutyCyc;
  logic [7:0]      ucpCyc;
  int              mismatches;
  int              samples_checked;
  int              cycles;
  int              highEdges;
  int              lowCycles;
  int              stopBit [6] = '{15, 12, 9, 6, 5, 0};
  logic            stopVal [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  always_comb begin
    flagsAsync = flags;
    flagsAsync.errorAboveRamp = errorAboveRamp;
    flagsAsync.senseBelowUcp = senseBelowUcp;
  end

  cepwm_sequencer #(.ADAPTER_GOOD_OUT_CYC(10), .DET_CYC(20), .CE_CYC(CE_CYC), .STEP_CYC(STEP_CYC), .PER_CYC(64))
    u_cepwm_sequencer (.clk(clk), .rst_n(rst_n), .flagsAsync(flagsAsync),
    .chargeVoltageSetting(chargeVoltageSetting), .chargeCurrentSetting(chargeCurrentSetting),
    .inputCurrentLimit(inputCurrentLimit), .inputCurrentLimitWrite(inputCurrentLimitWrite),
    .adapterGoodOutOe(adapterGoodOutOe), .inputCurrentMonitorEnable(inputCurrentMonitorEnable),
    .biasEnable(biasEnable), .chargeEnabled(chargeEnabled), .chargeRegulationLimit(chargeRegulationLimit),
    .inputLimitField(inputLimitField), .gates(gates));

  cepwm_power_stage u_cepwm_power_stage (.clk(clk), .gates(gates), .dutyCyc(dutyCyc), .ucpCyc(ucpCyc),
    .errorAboveRamp(errorAboveRamp), .senseBelowUcp(senseBelowUcp), .overlapSeen(overlapSeen));

  // ==========================================================================
  // Clock, watchdog and gate monitors
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    prevHigh <= gates.highGate;
    if (gates.highGate && !prevHigh) highEdges++;
    if (gates.lowGate) lowCycles++;
    if (gates !== 2'b00) gateSeen = 1'b1;
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic write_limit(input logic [15:0] d);
    @(posedge clk);
    inputCurrentLimit <= d;
    inputCurrentLimitWrite <= 1'b1;
    @(posedge clk);
    inputCurrentLimitWrite <= 1'b0;
    #1;
  endtask

  // A bounded wait keeps a stuck enable from hanging the run.
  task automatic wait_enable(input logic want);
    for (int i = 0; i < 400 && chargeEnabled !== want; i++) step(1);
  endtask

  task automatic stop_test();
    check("gatesNeverOverlap", 16'(overlapSeen), 16'h0000);
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    flags = '0;
    flags.supplyAbove4v = 1'b1;
    flags.supplyAbove4v5 = 1'b1;
    flags.logicAbove2v5 = 1'b1;
    flags.logicAbove2v35 = 1'b1;
    flags.adapterAboveBattery = 1'b1;
    flags.gateDriveValid = 1'b1;
    flags.referenceValid = 1'b1;
    {chargeVoltageSetting, chargeCurrentSetting, inputCurrentLimit} = '0;
    inputCurrentLimitWrite = 1'b0;
    {dutyCyc, ucpCyc} = {8'h14, 8'h3C};
    {mismatches, samples_checked, cycles, highEdges, lowCycles} = '0;
    {prevHigh, gateSeen} = 2'b00;
    step(12);
    check("resetGates", 16'(gates), 16'h0000);
    check("resetLimit", 16'(inputLimitField), 16'h0001);
    @(posedge clk) rst_n <= 1'b1;
    step(4);
    check("monitorOff", 16'(inputCurrentMonitorEnable), 16'h0000);
    check("goodHeldLow", 16'(adapterGoodOutOe), 16'h0001);
    @(posedge clk) flags.detectAbove0v6 <= 1'b1;
    step(4);
    check("biasOn", 16'({biasEnable, inputCurrentMonitorEnable, adapterGoodOutOe}), 16'h0007);
    @(posedge clk) flags.detectAbove2v4 <= 1'b1;
    step(5);
    check("goodEarly", 16'(adapterGoodOutOe), 16'h0001);
    step(12);
    check("goodReleased", 16'(adapterGoodOutOe), 16'h0000);
    $display("test adapter detect done");
    @(posedge clk) chargeVoltageSetting <= 16'h1000;
    chargeCurrentSetting <= 16'h0800;
    write_limit(16'h0200);
    check("limitField", 16'(inputLimitField), 16'h0004);
    step(30);
    check("noEnableWithoutPin", 16'(chargeEnabled), 16'h0000);
    @(posedge clk) flags.chargeEnablePin <= 1'b1;
    step(CE_CYC - 10);
    check("pinDelay", 16'(chargeEnabled), 16'h0000);
    wait_enable(1'b1);
    check("enabled", 16'(chargeEnabled), 16'h0001);
    check("rampStart", 16'(chargeRegulationLimit <= 6'h02), 16'h0001);
    step(6 * STEP_CYC);
    check("rampMid", 16'(chargeRegulationLimit < 6'h10), 16'h0001);
    step(2 * STEP_CYC + 8);
    check("rampEnd", 16'(chargeRegulationLimit), 16'h0010);
    @(posedge clk) chargeCurrentSetting <= 16'h0A00;
    step(5);
    check("liveChange", 16'(chargeRegulationLimit), 16'h0014);
    highEdges = 0;
    lowCycles = 0;
    step(256);
    check("cycleStarts", 16'(highEdges), 16'h0004);
    check("lowHolds", 16'(lowCycles > 120), 16'h0001);
    $display("test soft start and switching done");
    @(posedge clk) flags.errorBelowFloor <= 1'b1;
    step(72);
    gateSeen = 1'b0;
    step(128);
    check("zeroDuty", 16'(gateSeen), 16'h0000);
    @(posedge clk) flags.bootLow <= 1'b1;
    step(70);
    {lowCycles, highEdges} = '0;
    step(128);
    check("bootPulse", 16'(lowCycles), 16'h000A);
    check("bootNoHigh", 16'(highEdges), 16'h0000);
    @(posedge clk) flags.bootLow <= 1'b0;
    @(posedge clk) flags.errorBelowFloor <= 1'b0;
    $display("test zero duty done");
    @(posedge clk) ucpCyc <= 8'h08;
    step(70);
    lowCycles = 0;
    step(128);
    check("ucpCutoff", 16'(lowCycles >= 26 && lowCycles <= 40), 16'h0001);
    @(posedge clk) ucpCyc <= 8'h3C;
    step(70);
    $display("test undercurrent cutoff done");
    for (int k = 0; k < 6; k++) begin
      @(posedge clk) flags[stopBit[k]] <= stopVal[k];
      step(4);
      check("stopCause", 16'(chargeEnabled), 16'h0000);
      @(posedge clk) flags[stopBit[k]] <= !stopVal[k];
      wait_enable(1'b1);
      check("restart", 16'(chargeEnabled), 16'h0001);
    end
    @(posedge clk) chargeCurrentSetting <= 16'h0000;
    step(4);
    check("zeroCurrent", 16'(chargeEnabled), 16'h0000);
    @(posedge clk) chargeCurrentSetting <= 16'h0800;
    wait_enable(1'b1);
    write_limit(16'h0080);
    step(4);
    check("lowInputLimit", 16'(chargeEnabled), 16'h0000);
    $display("test stop conditions done");
    stop_test();
  end
endmodule
